// ### cmd_timing_defs.vh
// Constants for the command-path timing controller.
// Assumes a 200 MHz system clock (5 ns period).
`ifndef CMD_TIMING_DEFS_VH
`define CMD_TIMING_DEFS_VH
`define CLK_PERIOD_NS 5
// Register offsets (word addresses, one per register, consecutive).
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h1
`define OFF_MASK 4'h2
`define OFF_GRADE 4'h3
`define OFF_CMD 4'h4
`define OFF_TIMES 4'h5
// Control fields.
`define CTRL_PSM_ENTER 0
`define CTRL_PSM_EXIT 1
`define CTRL_CT_ENTER 2
`define CTRL_CAL_EN 3
`define CTRL_GEARDOWN 4
`define CTRL_PERSIST 5
`define CTRL_EXIT_CS_LOW 6
`define CTRL_ISSUE 7
// Status bits.
`define ST_ALERT 0
`define ST_RECOVERED 1
`define ST_PSM_IN 2
`define ST_PSM_OUT 3
`define ST_CT_IN 4
`define ST_CMD_DONE 5
`define ST_REFUSED 6
`define ST_BITS 7
// Timing in ns for the NS names, in clocks for the rest.
`define MODE_UPDATE_NS 15
`define MODE_UPDATE_NCK 24
`define CMD_PASS_DISABLE_NS 10
`define CLK_VALID_SRX_NS 10
`define SR_EXIT_NS 170
`define DLL_RELOCK_NCK 597
`define SETUP_HOLD_NS 1
`define PD_EXIT_NS 6
`define CS_LOW_HOLD_MIN_NS 12
`define CS_LOW_HOLD_MARGIN_NS 10
`define TEST_ENTRY_NS 200
`define TEST_VALID_NS 200
`define PARITY_RESP_BASE 43
`define PARITY_RESP_STEP 7
`define CAL_SLOWEST 3
`define CAL_MIDDLE 4
`define CAL_FASTEST 5
`define PARITY_LAT_SLOW 4
`define PARITY_LAT_FAST 5
`endif

// ### cmd_log_mem.v
// Small command log memory, registered read data.
// Assumes one clock; write and read in the same cycle are independent.
`timescale 1ns/100ps
`default_nettype none
module cmd_log_mem
(
    // Clock.
    input wire clk,
    // Write port.
    input wire wr_en,
    input wire [2:0] wr_addr,
    input wire [31:0] wr_data,
    // Read port.
    input wire [2:0] rd_addr,
    output reg [31:0] rd_data
);
    reg [31:0] mem [0:7];
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ### cmd_timing_ctrl.v
// Controller side of a memory command path: parity recovery, command
// latency, power saving entry and exit, and connectivity test entry.
// Assumes all memory pins are synchronous to CLK.
// Notes on behaviour
// - In persistent parity mode, send only deselects within 43..64 clocks; recovery does not hold off the power saving entry command.
// - Command follows chip select low by 3, 4 or 5 clocks.
// - No command latency while gear-down mode is active.
// - Keep clock valid that long after power saving entry.
// - Restore valid clock before power saving exit.
// - Wait self-refresh exit time before unlocked commands.
// - Add relock time before commands needing a locked loop.
// - Set chip select ahead of clock enable rise by setup plus hold.
// - High-hold exit keeps chip select high the power-down exit time.
// - Low-hold exit keeps chip select low 12 ns to exit minus 10 ns.
// - Raise test enable 200 ns before chip select goes low.
`include "cmd_timing_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module cmd_timing_ctrl
(
    // Clock and reset.
    input wire CLK,
    input wire SYS_RST,
    // Avalon-MM slave.
    input wire [3:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    // Interrupt.
    output reg IRQ,
    // Memory pins.
    output reg CS_N,
    output reg CKE,
    output reg CLK_EN,
    output reg TEST_ENABLE_PIN,
    output reg CMD_VALID,
    output reg [23:0] CMD_BITS,
    input wire ALERT_N
);
    function [15:0] ns2ck;
        input [15:0] ns;
        begin
            ns2ck = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
        end
    endfunction
    function [15:0] max16;
        input [15:0] a;
        input [15:0] b;
        begin
            max16 = (a > b) ? a : b;
        end
    endfunction
    localparam [15:0] MODE_UPDATE_CK = max16(`MODE_UPDATE_NCK,
        ns2ck(`MODE_UPDATE_NS));
    localparam [15:0] PSM_ENTRY_CK = MODE_UPDATE_CK +
        ns2ck(`CMD_PASS_DISABLE_NS);
    localparam [15:0] CLK_VALID_CK = ns2ck(`CLK_VALID_SRX_NS);
    localparam [15:0] EXIT_CK = ns2ck(`SR_EXIT_NS);
    localparam [15:0] EXIT_DLL_CK = EXIT_CK + `DLL_RELOCK_NCK;
    localparam [15:0] SETUP_CK = ns2ck(`SETUP_HOLD_NS);
    localparam [15:0] HH_CK = ns2ck(`PD_EXIT_NS);
    localparam [15:0] LH_CK = ns2ck(`CS_LOW_HOLD_MIN_NS);
    localparam [15:0] TEST_CK = ns2ck(`TEST_ENTRY_NS);
    localparam [15:0] TEST_VALID_CK = ns2ck(`TEST_VALID_NS);
    localparam [8:0] S_IDLE = 9'h001;
    localparam [8:0] S_CAL = 9'h002;
    localparam [8:0] S_PSM_HOLD = 9'h004;
    localparam [8:0] S_PSM = 9'h008;
    localparam [8:0] S_CLK_UP = 9'h010;
    localparam [8:0] S_CS_SET = 9'h020;
    localparam [8:0] S_EXIT = 9'h040;
    localparam [8:0] S_TEST_EN = 9'h080;
    localparam [8:0] S_TEST = 9'h100;
    reg [8:0] state_reg;
    reg [15:0] cnt_reg;
    reg [7:0] ctrl_reg;
    reg [1:0] grade_reg;
    reg [23:0] cmd_reg;
    reg [`ST_BITS-1:0] status_reg;
    reg [`ST_BITS-1:0] mask_reg;
    reg [`ST_BITS-1:0] ev;
    reg [7:0] alert_cnt_reg;
    reg in_alert_reg;
    reg recover_reg;
    reg [15:0] ready_cnt_reg;
    reg dll_ok_reg;
    reg [2:0] log_ptr_reg;
    wire [31:0] log_rd;
    wire acc = AVS_READ | AVS_WRITE;
    wire wr = AVS_WRITE & ~AVS_WAITREQUEST;
    wire [7:0] cal_ck = (grade_reg == 2'd0) ? `CAL_SLOWEST :
        (grade_reg == 2'd3) ? `CAL_FASTEST : `CAL_MIDDLE;
    wire [31:0] resp_full = `PARITY_RESP_BASE + grade_reg * `PARITY_RESP_STEP;
    wire [7:0] resp_ck = resp_full[7:0];
    wire cal_on = ctrl_reg[`CTRL_CAL_EN] & ~ctrl_reg[`CTRL_GEARDOWN];
    wire issue = wr && AVS_ADDRESS == `OFF_CMD;
    ////////////////////////////////////////////////////////////////////////
    // Register bus: one wait cycle, then the access completes.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0;
            ctrl_reg <= 8'h00;
            grade_reg <= 2'h0;
            mask_reg <= {`ST_BITS{1'b0}};
            cmd_reg <= 24'h0;
        end
        else
        begin
            AVS_WAITREQUEST <= ~(acc & AVS_WAITREQUEST);
            if (state_reg == S_IDLE && dll_ok_reg)
            begin
                ctrl_reg[`CTRL_PSM_ENTER] <= 1'b0;
            end
            ctrl_reg[`CTRL_PSM_EXIT] <= 1'b0;
            ctrl_reg[`CTRL_CT_ENTER] <= 1'b0;
            if (wr && AVS_ADDRESS == `OFF_CTRL)
            begin
                ctrl_reg <= AVS_WRITEDATA[7:0];
            end
            if (wr && AVS_ADDRESS == `OFF_MASK)
            begin
                mask_reg <= AVS_WRITEDATA[`ST_BITS-1:0];
            end
            if (wr && AVS_ADDRESS == `OFF_GRADE)
            begin
                grade_reg <= AVS_WRITEDATA[1:0];
            end
            if (issue)
            begin
                cmd_reg <= AVS_WRITEDATA[23:0];
            end
            if (AVS_READ & AVS_WAITREQUEST)
            begin
                case (AVS_ADDRESS)
                `OFF_CTRL: AVS_READDATA <= {24'h0, ctrl_reg};
                `OFF_STATUS: AVS_READDATA <= {25'h0, status_reg};
                `OFF_MASK: AVS_READDATA <= {25'h0, mask_reg};
                `OFF_GRADE: AVS_READDATA <= {21'h0, state_reg, grade_reg};
                `OFF_CMD: AVS_READDATA <= {8'h0, cmd_reg};
                `OFF_TIMES: AVS_READDATA <= log_rd;
                default: AVS_READDATA <= 32'h0;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Alert tracking and persistent parity recovery.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            alert_cnt_reg <= 8'h0;
            in_alert_reg <= 1'b0;
            recover_reg <= 1'b0;
        end
        else
        begin
            if (~ALERT_N)
            begin
                in_alert_reg <= 1'b1;
                if (alert_cnt_reg != 8'hff)
                begin
                    alert_cnt_reg <= alert_cnt_reg + 8'h1;
                end
                if (ctrl_reg[`CTRL_PERSIST])
                begin
                    recover_reg <= 1'b1;
                end
            end
            else
            begin
                in_alert_reg <= 1'b0;
                alert_cnt_reg <= 8'h0;
                if (in_alert_reg)
                begin
                    recover_reg <= 1'b0;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Sequencer for commands, power saving and connectivity test.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= S_IDLE;
            cnt_reg <= 16'h0;
            CS_N <= 1'b1;
            CKE <= 1'b1;
            CLK_EN <= 1'b1;
            TEST_ENABLE_PIN <= 1'b0;
            CMD_VALID <= 1'b0;
            CMD_BITS <= 24'h0;
            ready_cnt_reg <= 16'h0;
            dll_ok_reg <= 1'b1;
        end
        else
        begin
            CMD_VALID <= 1'b0;
            if (ready_cnt_reg != 16'h0)
            begin
                ready_cnt_reg <= ready_cnt_reg - 16'h1;
            end
            if (ready_cnt_reg == 16'h1)
            begin
                dll_ok_reg <= 1'b1;
            end
            cnt_reg <= (cnt_reg != 16'h0) ? cnt_reg - 16'h1 : 16'h0;
            case (state_reg)
            S_IDLE:
            begin
                CS_N <= 1'b1;
                if (ctrl_reg[`CTRL_CT_ENTER])
                begin
                    TEST_ENABLE_PIN <= 1'b1;
                    cnt_reg <= TEST_CK;
                    state_reg <= S_TEST_EN;
                end
                else if (ctrl_reg[`CTRL_PSM_ENTER] && dll_ok_reg)
                begin
                    CS_N <= 1'b0;
                    cnt_reg <= PSM_ENTRY_CK + 16'h1;
                    state_reg <= S_PSM_HOLD;
                end
                else if (issue && !recover_reg && dll_ok_reg
                    && ready_cnt_reg <= EXIT_DLL_CK - EXIT_CK)
                begin
                    CS_N <= 1'b0;
                    cnt_reg <= cal_on ? {8'h0, cal_ck} : 16'h0;
                    state_reg <= S_CAL;
                end
            end
            S_CAL:
            begin
                if (cnt_reg <= 16'h1)
                begin
                    CMD_VALID <= 1'b1;
                    CMD_BITS <= cmd_reg;
                    state_reg <= S_IDLE;
                end
            end
            S_PSM_HOLD:
            begin
                if (cnt_reg == PSM_ENTRY_CK + 16'h1)
                begin
                    CMD_VALID <= 1'b1;
                    CMD_BITS <= cmd_reg;
                end
                else
                begin
                    CS_N <= 1'b1;
                end
                if (cnt_reg == 16'h0)
                begin
                    CLK_EN <= 1'b0;
                    state_reg <= S_PSM;
                end
            end
            S_PSM:
            begin
                if (ctrl_reg[`CTRL_PSM_EXIT])
                begin
                    CLK_EN <= 1'b1;
                    cnt_reg <= CLK_VALID_CK;
                    state_reg <= S_CLK_UP;
                end
            end
            S_CLK_UP:
            begin
                if (cnt_reg == 16'h0)
                begin
                    CS_N <= ~ctrl_reg[`CTRL_EXIT_CS_LOW];
                    CKE <= 1'b0;
                    cnt_reg <= SETUP_CK;
                    state_reg <= S_CS_SET;
                end
            end
            S_CS_SET:
            begin
                if (cnt_reg == 16'h0)
                begin
                    CKE <= 1'b1;
                    cnt_reg <= CS_N ? HH_CK : LH_CK;
                    state_reg <= S_EXIT;
                end
            end
            S_EXIT:
            begin
                if (cnt_reg == 16'h0)
                begin
                    CS_N <= 1'b1;
                    ready_cnt_reg <= EXIT_DLL_CK;
                    dll_ok_reg <= 1'b0;
                    state_reg <= S_IDLE;
                end
            end
            S_TEST_EN:
            begin
                if (cnt_reg == 16'h0)
                begin
                    CS_N <= 1'b0;
                    cnt_reg <= TEST_VALID_CK;
                    state_reg <= S_TEST;
                end
            end
            S_TEST:
            begin
                if (ctrl_reg[`CTRL_PSM_EXIT])
                begin
                    TEST_ENABLE_PIN <= 1'b0;
                    CS_N <= 1'b1;
                    state_reg <= S_IDLE;
                end
            end
            default:
            begin
                state_reg <= S_IDLE;
            end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Events, sticky status and interrupt; set wins over clear.
    always @*
    begin
        ev = {`ST_BITS{1'b0}};
        ev[`ST_ALERT] = ~ALERT_N & ~in_alert_reg;
        ev[`ST_RECOVERED] = recover_reg & ALERT_N & in_alert_reg;
        ev[`ST_PSM_IN] = (state_reg == S_PSM_HOLD) && cnt_reg == 16'h0;
        ev[`ST_PSM_OUT] = (state_reg == S_EXIT) && cnt_reg == 16'h0;
        ev[`ST_CT_IN] = (state_reg == S_TEST_EN) && cnt_reg == 16'h0;
        ev[`ST_CMD_DONE] = (state_reg == S_CAL) && cnt_reg <= 16'h1;
        ev[`ST_REFUSED] = issue && (recover_reg || state_reg != S_IDLE);
    end
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            status_reg <= {`ST_BITS{1'b0}};
            IRQ <= 1'b0;
            log_ptr_reg <= 3'h0;
        end
        else
        begin
            if (wr && AVS_ADDRESS == `OFF_STATUS)
            begin
                status_reg <= (status_reg & ~AVS_WRITEDATA[`ST_BITS-1:0])
                    | ev;
            end
            else
            begin
                status_reg <= status_reg | ev;
            end
            IRQ <= |(status_reg & mask_reg);
            if (ev[`ST_ALERT])
            begin
                log_ptr_reg <= log_ptr_reg + 3'h1;
            end
        end
    end
    cmd_log_mem log_mem
    (
        .clk(CLK),
        .wr_en(ev[`ST_ALERT]),
        .wr_addr(log_ptr_reg),
        .wr_data({resp_ck, 8'h0, cmd_reg[15:0]}),
        .rd_addr(log_ptr_reg - 3'h1),
        .rd_data(log_rd)
    );
endmodule
`default_nettype wire

// ### cmd_timing_ctrl_chk.sv
// Checker for the command-path timing controller, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cmd_timing_ctrl_chk
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Memory pins.
    input wire logic CS_N,
    input wire logic CKE,
    input wire logic CLK_EN,
    input wire logic TEST_ENABLE_PIN,
    input wire logic CMD_VALID,
    input wire logic ALERT_N
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    int ten_cnt;
    int exit_cnt;
    int alert_cnt;
    ////////////////////////////////////////////////////////////////////////
    // Cycle counters since test enable, exit and alert.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ten_cnt <= 0;
            exit_cnt <= 1000;
            alert_cnt <= 0;
        end
        else
        begin
            ten_cnt <= !TEST_ENABLE_PIN ? 0 : (ten_cnt < 1000 ? ten_cnt + 1 : ten_cnt);
            exit_cnt <= $rose(CKE) ? 0 : (exit_cnt < 1000 ? exit_cnt + 1 : exit_cnt);
            alert_cnt <= ALERT_N ? 0 : (alert_cnt < 1000 ? alert_cnt + 1 : alert_cnt);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Exit sequences.
    sequence s_exit_hi;
        $rose(CKE) && CS_N;
    endsequence
    sequence s_exit_lo;
        $rose(CKE) && !CS_N;
    endsequence
    a_ten_before_cs: assert property ($fell(CS_N) && TEST_ENABLE_PIN |-> ten_cnt >= 40)
        else $error("chip select fell too soon after test enable");
    a_clk_before_exit: assert property ($rose(CKE) |-> CLK_EN && $past(CLK_EN, 2))
        else $error("clock not valid before exit");
    a_cs_setup_exit: assert property ($rose(CKE) |-> $stable(CS_N))
        else $error("chip select changed at clock enable rise");
    a_cs_high_hold: assert property (s_exit_hi |=> CS_N [*2])
        else $error("chip select high hold too short");
    a_cs_low_hold: assert property (s_exit_lo |=> (!CS_N) [*2] ##[1:31] CS_N)
        else $error("chip select low hold out of range");
    a_exit_cmd_wait: assert property (CMD_VALID |-> exit_cnt >= 33)
        else $error("command too soon after exit");
    a_alert_des_only: assert property (alert_cnt >= 64 |-> CS_N && !CMD_VALID)
        else $error("command during parity recovery");
    a_cmd_after_cs: assert property (CMD_VALID |-> !CS_N && !$past(CS_N))
        else $error("command without chip select lead");
endmodule
bind cmd_timing_ctrl cmd_timing_ctrl_chk u_chk
(
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .CS_N(CS_N),
    .CKE(CKE),
    .CLK_EN(CLK_EN),
    .TEST_ENABLE_PIN(TEST_ENABLE_PIN),
    .CMD_VALID(CMD_VALID),
    .ALERT_N(ALERT_N)
);
`default_nettype wire

// ### mem_dev_model.sv
// Behavioural memory device: counts accepted commands and raises alert.
// Assumes the bench flags which command carries a parity error.
`timescale 1ns/100ps
`default_nettype none
module mem_dev_model
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Memory pins.
    input wire logic CS_N,
    input wire logic CKE,
    input wire logic CLK_EN,
    input wire logic CMD_VALID,
    output logic ALERT_N,
    // Bench controls.
    input wire logic [1:0] grade,
    input wire logic inject
);
    int pend;
    int width;
    int hits;
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ALERT_N <= 1'b1;
            pend <= 0;
            width <= 0;
            hits <= 0;
        end
        else
        begin
            if (CMD_VALID && !CS_N && CKE && CLK_EN && ALERT_N && pend == 0)
            begin
                hits <= hits + 1;
                if (inject)
                    pend <= (grade == 2'h3 ? 5 : 4) + 1;
            end
            if (pend > 1)
                pend <= pend - 1;
            else if (pend == 1)
            begin
                pend <= 0;
                ALERT_N <= 1'b0;
                width <= 48 + 8 * grade;
            end
            if (width > 1)
                width <= width - 1;
            else if (width == 1)
            begin
                width <= 0;
                ALERT_N <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test_cmd_timing_ctrl.sv
// Self-checking bench for the command-path timing controller.
// Assumes the register map of the shared defines header.
`include "cmd_timing_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module test_cmd_timing_ctrl;
    logic CLK;
    logic SYS_RST;
    logic [3:0] AVS_ADDRESS;
    logic AVS_READ;
    logic AVS_WRITE;
    logic [31:0] AVS_WRITEDATA;
    logic [1:0] grade;
    logic inject;
    wire [31:0] AVS_READDATA;
    wire [23:0] CMD_BITS;
    wire AVS_WAITREQUEST, IRQ, CS_N, CKE, CLK_EN, TEST_ENABLE_PIN;
    wire CMD_VALID, ALERT_N;
    int fails = 0;
    int total_checks = 0;
    int lat_cnt, last_lat, ten_cnt, ten_gap, g, m, e;
    logic cs_prev = 1'b1;
    cmd_timing_ctrl dut (.CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ,
        .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .IRQ,
        .CS_N, .CKE, .CLK_EN, .TEST_ENABLE_PIN, .CMD_VALID, .CMD_BITS,
        .ALERT_N);
    mem_dev_model mdl (.CLK, .SYS_RST, .CS_N, .CKE, .CLK_EN, .CMD_VALID,
        .ALERT_N, .grade, .inject);
    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and latency monitor.
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial
    begin
        repeat (60000) @(posedge CLK);
        fails++;
        conclude;
    end
    always @(posedge CLK)
    begin
        lat_cnt++;
        ten_cnt = TEST_ENABLE_PIN === 1'b1 ? ten_cnt + 1 : 0;
        if (cs_prev === 1'b1 && CS_N === 1'b0)
        begin
            lat_cnt = 0;
            ten_gap = ten_cnt;
        end
        if (CMD_VALID === 1'b1)
            last_lat = lat_cnt;
        cs_prev = CS_N;
    end
    ////////////////////////////////////////////////////////////////////////
    // Bus and comparison tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (AVS_WAITREQUEST !== 1'b0 && n < 100);
        q = AVS_READDATA;
        if (n >= 100)
            fails++;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdm(input logic [3:0] a, input logic [31:0] msk,
        input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & msk, exp);
    endtask
    task automatic poll(input int b);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, `OFF_STATUS, 32'h0, q);
            n++;
        end
        while (q[b] !== 1'b1 && n < 400);
        chk(q[b], 32'h1);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial
    begin
        SYS_RST = 1'b1;
        AVS_ADDRESS = 4'h0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = 32'h0;
        grade = 2'h0;
        inject = 1'b0;
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        chk({CS_N, CKE, CLK_EN, TEST_ENABLE_PIN, CMD_VALID, IRQ}, 32'h38);
        wr(4'hf, 32'hffff_ffff);
        rdm(4'hf, 32'hffff_ffff, 32'h0);
        $display("test reset and unmapped done");
        for (g = 0; g < 4; g++)
        begin
            grade <= g[1:0];
            wr(`OFF_GRADE, g);
            rdm(`OFF_GRADE, 32'h3, g);
            for (m = 0; m < 3; m++)
            begin
                wr(`OFF_CTRL, m == 0 ? 32'h08 : (m == 1 ? 32'h18 : 32'h00));
                wr(`OFF_CMD, 32'h000120 + g);
                poll(`ST_CMD_DONE);
                chk(last_lat, m > 0 ? 1 : (g == 0 ? 3 : (g == 3 ? 5 : 4)));
                wr(`OFF_STATUS, 32'h7f);
            end
        end
        $display("test command latency done");
        wr(`OFF_MASK, 32'h1 << `ST_CMD_DONE);
        wr(`OFF_CMD, 32'h000200);
        poll(`ST_CMD_DONE);
        repeat (2) @(posedge CLK);
        chk(IRQ, 32'h1);
        wr(`OFF_STATUS, 32'h1 << `ST_CMD_DONE);
        repeat (2) @(posedge CLK);
        chk(IRQ, 32'h0);
        wr(`OFF_MASK, 32'h0);
        wr(`OFF_CMD, 32'h000201);
        poll(`ST_CMD_DONE);
        repeat (2) @(posedge CLK);
        chk(IRQ, 32'h0);
        wr(`OFF_STATUS, 32'h7f);
        $display("test interrupt done");
        wr(`OFF_CTRL, 32'h20);
        inject <= 1'b1;
        wr(`OFF_CMD, 32'h000300);
        poll(`ST_ALERT);
        inject <= 1'b0;
        wr(`OFF_CMD, 32'h000301);
        rdm(`OFF_STATUS, 32'h1 << `ST_REFUSED, 32'h1 << `ST_REFUSED);
        poll(`ST_RECOVERED);
        rdm(`OFF_TIMES, 32'hffff_ffff, 32'h4000_0300);
        wr(`OFF_STATUS, 32'h7f);
        $display("test parity recovery done");
        for (e = 0; e < 2; e++)
        begin
            wr(`OFF_CTRL, e ? 32'h41 : 32'h01);
            poll(`ST_PSM_IN);
            wr(`OFF_CTRL, e ? 32'h42 : 32'h02);
            poll(`ST_PSM_OUT);
            chk(CKE, 32'h1);
            wr(`OFF_CMD, 32'h000400);
            wr(`OFF_STATUS, 32'h7f);
        end
        $display("test power saving done");
        wr(`OFF_CTRL, 32'h04);
        poll(`ST_CT_IN);
        chk(TEST_ENABLE_PIN, 32'h1);
        chk(ten_gap > 40, 32'h1);
        wr(`OFF_CTRL, 32'h02);
        $display("test connectivity done");
        conclude;
    end
endmodule
`default_nettype wire
